// file: tip_pkg.sv
// Summary of operation
// - Ports of 1, 4, 8, 16 and 32 bits all reach the pins from pin 0 upward, sharing the low pins.
// - All pins of one port share one direction, input or output.
// - Ports drive pins or sample them, optionally waiting for a pin condition.
// - Register accesses to a port finish after one wait state when data allows.
// - Open-drain: a zero pulls the pin low, a one releases it.
// - Data passes through a serializer and a transfer register.
// - Each port has a 16-bit counter timing its transfers.
// - The counter reads at any time and can delay a transfer.
// - Each transfer captures the counter as a timestamp.
// - Pin events go straight out as event lines, no interrupts.
// - Pins claimed by an enabled link are taken from every port.
// - A narrower enabled port wins shared pins over wider ports.
// - Unshared pins of a wider port stay with the wider port.
// - A port transfers at its full nominal width but drives only the pins that no narrower enabled port has won.
// - Six clock blocks; block 0 gives the 100MHz reference.
// - A clock block may take a 1-bit port pin as source and divide it.
// - Ports accept incoming strobes and produce outgoing strobes.
// - After reset every port uses clock block 0.
// - During reset every pin has its pull-down enabled.
package tip_pkg;
  localparam int CLK_HZ = 200000000;
  localparam int REF_HZ = 100000000;
  localparam int REF_DIV = CLK_HZ / REF_HZ;
  localparam int NPORT = 5;
  localparam int NCB = 6;
  localparam int DW = 32;
  localparam int AW = 12;

  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_DATA = 6'h04;
  localparam logic [5:0] OFS_COND = 6'h08;
  localparam logic [5:0] OFS_TIME = 6'h0C;
  localparam logic [5:0] OFS_CNT = 6'h10;
  localparam logic [5:0] OFS_STAMP = 6'h14;
  localparam logic [5:0] OFS_STAT = 6'h18;
  localparam logic [3:0] RGN_PORT = 4'h0;
  localparam logic [3:0] RGN_CB = 4'h2;
  localparam logic [3:0] RGN_LINK = 4'h3;

  localparam int CTL_EN = 0;
  localparam int CTL_OUT = 1;
  localparam int CTL_OD = 2;
  localparam int CTL_CB = 3;
  localparam int CTL_CM = 6;
  localparam int CTL_STB = 8;
  localparam int CTL_W = 9;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [1:0] CM_NONE = 2'h0;
  localparam logic [1:0] CM_EQ = 2'h1;
  localparam logic [1:0] CM_NE = 2'h2;
  localparam int TIME_ARM = 16;
  localparam int CB_EXT = 0;
  localparam int CB_DIV = 8;
  localparam logic [15:0] CBCFG_RST = 16'h0000;

  function automatic int port_width(input int p);
    case (p)
      0: return 1;
      1: return 4;
      2: return 8;
      3: return 16;
      default: return 32;
    endcase
  endfunction
endpackage

// file: tip_port_unit.sv
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module tip_port_unit
  import tip_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [AW-1:0]     paddr,
  input  wire logic [DW-1:0]     pwdata,
  output logic      [DW-1:0]     prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [DW-1:0]     pin_i,
  output logic      [DW-1:0]     pin_o,
  output logic      [DW-1:0]     pin_oe,
  output logic      [DW-1:0]     pin_pd,
  input  wire logic [NPORT-1:0]  strobe_in_i,
  output logic      [NPORT-1:0]  strobe_out_signal,
  output logic      [NPORT-1:0]  port_event
);
  logic [CTL_W-1:0] ctrl_reg [NPORT];
  logic [DW-1:0]    cond_reg [NPORT];
  logic [15:0]      tcnt_reg [NPORT];
  logic             timed_reg [NPORT];
  logic [15:0]      cnt_reg [NPORT];
  logic [15:0]      stamp_reg [NPORT];
  logic [DW-1:0]    xfer_reg [NPORT];
  logic             full_reg [NPORT];
  logic [DW-1:0]    pv_reg [NPORT];
  logic [15:0]      cbcfg_reg [NCB];
  logic [7:0]       dcnt_reg [NCB];
  logic [NCB-1:0]   cb_tick_reg;
  logic [7:0]       tick_all;
  logic [7:0]       ref_cnt_reg;
  logic             ext_prev_reg;
  logic             ref_tick;
  logic             ext_edge;
  logic [DW-1:0]    link_reg;
  logic [DW-1:0]    pin_o_reg;
  logic [DW-1:0]    pin_oe_reg;
  logic [DW-1:0]    pin_o_next;
  logic [DW-1:0]    pin_oe_next;
  logic [DW-1:0]    pin_pd_reg;
  logic [DW-1:0]    prdata_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  logic [NPORT-1:0] sto_reg;
  logic [NPORT-1:0] evt_reg;
  logic [DW-1:0]    rd_data;
  logic             rd_ok;
  logic             rd_err;
  logic             fire;
  logic [2:0]       acc_idx;
  logic [3:0]       acc_rgn;
  logic [5:0]       acc_ofs;

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign pin_o             = pin_o_reg;
  assign pin_oe            = pin_oe_reg;
  assign pin_pd            = pin_pd_reg;
  assign strobe_out_signal = sto_reg;
  assign port_event        = evt_reg;

  assign acc_rgn = paddr[11:8];
  assign acc_idx = (acc_rgn == RGN_CB) ? paddr[4:2] : paddr[8:6];
  assign acc_ofs = paddr[5:0];
  // The completing edge is the only one at which writes land and reads consume data.
  assign fire = psel & penable & pready_reg;

  // Five windows of 0x40 bytes spill into region 1, so only the top three bits pick the area.
  function automatic logic port_rgn(input logic [AW-1:0] a);
    return a[11:9] == RGN_PORT[3:1];
  endfunction

  function automatic logic port_hit(input logic [AW-1:0] a, input int p);
    return port_rgn(a) && (a[8:6] == 3'(p));
  endfunction

  // Pull-downs stay on only while reset is asserted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_pd_reg <= '1;
    end else begin
      pin_pd_reg <= '0;
    end
  end

  // Clock blocks: block 0 is the fixed reference, the rest may divide it or pin 0.
  assign ref_tick = (ref_cnt_reg == 8'(REF_DIV - 1));
  assign ext_edge = pin_i[0] & ~ext_prev_reg;
  assign tick_all = {{(8 - NCB){1'b0}}, cb_tick_reg};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_reg  <= 8'h00;
      ext_prev_reg <= 1'b0;
    end else begin
      ref_cnt_reg  <= ref_tick ? 8'h00 : ref_cnt_reg + 8'h01;
      ext_prev_reg <= pin_i[0];
    end
  end

  for (genvar k = 0; k < NCB; k++) begin : g_cb
    logic src;
    assign src = (k != 0 && cbcfg_reg[k][CB_EXT]) ? ext_edge : ref_tick;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cbcfg_reg[k] <= CBCFG_RST;
      end else if (fire && pwrite && k != 0 && acc_rgn == RGN_CB && acc_idx == 3'(k)
                   && paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0) begin
        cbcfg_reg[k] <= pwdata[15:0];
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dcnt_reg[k]    <= 8'h00;
        cb_tick_reg[k] <= 1'b0;
      end else begin
        cb_tick_reg[k] <= 1'b0;
        if (src) begin
          if (dcnt_reg[k] >= cbcfg_reg[k][CB_DIV+:8]) begin
            dcnt_reg[k]    <= 8'h00;
            cb_tick_reg[k] <= 1'b1;
          end else begin
            dcnt_reg[k] <= dcnt_reg[k] + 8'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_reg <= '0;
    end else if (fire && pwrite && acc_rgn == RGN_LINK && acc_ofs == 6'h00
                 && paddr[7:6] == 2'h0) begin
      link_reg <= pwdata;
    end
  end

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    localparam int W = port_width(p);
    localparam logic [5:0] SLOTS = 6'(DW / W);
    logic [DW-1:0] sh_reg;
    logic [5:0]    scnt_reg;
    logic [DW-1:0] vin;
    logic          tk;
    logic          tok;
    logic          match;
    logic          is_out;
    logic          hit;
    logic [1:0]    cm;

    assign hit    = port_hit(paddr, p);
    assign is_out = ctrl_reg[p][CTL_OUT];
    assign cm     = ctrl_reg[p][CTL_CM+:2];
    assign tk     = tick_all[ctrl_reg[p][CTL_CB+:3]];
    assign vin    = DW'(pin_i[W-1:0]);
    assign tok    = !timed_reg[p] || cnt_reg[p] == tcnt_reg[p];
    assign match  = (cm == CM_EQ) ? (vin == cond_reg[p]) :
                    (cm == CM_NE) ? (vin != cond_reg[p]) : 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl_reg[p] <= CTRL_RST;
        cond_reg[p] <= '0;
      end else if (fire && pwrite && hit) begin
        if (acc_ofs == OFS_CTRL) begin
          ctrl_reg[p] <= pwdata[CTL_W-1:0];
        end
        if (acc_ofs == OFS_COND) begin
          cond_reg[p] <= pwdata & DW'((64'h1 << W) - 64'h1);
        end
      end
    end

    // Counter, transfer register and serializer share one process so a tick
    // and a core access in the same cycle are resolved in one place.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg[p]   <= 16'h0000;
        stamp_reg[p] <= 16'h0000;
        tcnt_reg[p]  <= 16'h0000;
        timed_reg[p] <= 1'b0;
        xfer_reg[p]  <= '0;
        full_reg[p]  <= 1'b0;
        pv_reg[p]    <= '0;
        sh_reg       <= '0;
        scnt_reg     <= 6'h00;
        sto_reg[p]   <= 1'b0;
        evt_reg[p]   <= 1'b0;
      end else begin
        sto_reg[p] <= 1'b0;
        evt_reg[p] <= is_out ? !full_reg[p] : full_reg[p];
        if (fire && pwrite && hit && acc_ofs == OFS_TIME) begin
          tcnt_reg[p]  <= pwdata[15:0];
          timed_reg[p] <= pwdata[TIME_ARM];
        end
        if (fire && hit && acc_ofs == OFS_DATA) begin
          if (pwrite && is_out) begin
            xfer_reg[p] <= pwdata;
            full_reg[p] <= 1'b1;
          end else if (!pwrite && !is_out) begin
            full_reg[p] <= 1'b0;
          end
        end
        if (tk) begin
          cnt_reg[p] <= cnt_reg[p] + 16'h0001;
          if (is_out) begin
            if (scnt_reg == 6'h00 && full_reg[p] && tok) begin
              pv_reg[p]    <= xfer_reg[p];
              sh_reg       <= xfer_reg[p] >> W;
              scnt_reg     <= SLOTS - 6'h01;
              full_reg[p]  <= 1'b0;
              stamp_reg[p] <= cnt_reg[p];
              timed_reg[p] <= 1'b0;
              sto_reg[p]   <= 1'b1;
            end else if (scnt_reg != 6'h00) begin
              pv_reg[p]  <= sh_reg;
              sh_reg     <= sh_reg >> W;
              scnt_reg   <= scnt_reg - 6'h01;
              sto_reg[p] <= 1'b1;
            end
          end else if (!ctrl_reg[p][CTL_STB] || strobe_in_i[p]) begin
            if (cm != CM_NONE) begin
              if (!full_reg[p] && match && tok) begin
                xfer_reg[p]  <= vin;
                full_reg[p]  <= 1'b1;
                stamp_reg[p] <= cnt_reg[p];
                timed_reg[p] <= 1'b0;
              end
            end else if (scnt_reg != 6'h00 || tok) begin
              sh_reg <= (sh_reg >> W) | (vin << (DW - W));
              if (scnt_reg == SLOTS - 6'h01) begin
                scnt_reg <= 6'h00;
                if (!full_reg[p]) begin
                  xfer_reg[p]  <= (sh_reg >> W) | (vin << (DW - W));
                  full_reg[p]  <= 1'b1;
                  stamp_reg[p] <= cnt_reg[p];
                  timed_reg[p] <= 1'b0;
                end
              end else begin
                scnt_reg <= scnt_reg + 6'h01;
              end
            end
          end
        end
      end
    end
  end

  // The lowest port index is the narrowest, so the loop runs downward and the last enabled claimant wins.
  always_comb begin
    pin_o_next  = '0;
    pin_oe_next = '0;
    for (int b = 0; b < DW; b++) begin
      for (int p = NPORT - 1; p >= 0; p--) begin
        if (ctrl_reg[p][CTL_EN] && b < port_width(p)) begin
          pin_o_next[b]  = pv_reg[p][b];
          pin_oe_next[b] = ctrl_reg[p][CTL_OUT] &
                           (!ctrl_reg[p][CTL_OD] | !pv_reg[p][b]);
        end
      end
      if (link_reg[b]) begin
        pin_oe_next[b] = 1'b0;
        pin_o_next[b]  = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o_reg  <= '0;
      pin_oe_reg <= '0;
    end else begin
      pin_o_reg  <= pin_o_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  // Only DATA may wait; everything else answers after one wait state.
  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b1;
    rd_err  = 1'b0;
    if (port_rgn(paddr) && acc_idx < 3'(NPORT)) begin
      case (acc_ofs)
        OFS_CTRL:  rd_data = DW'(ctrl_reg[acc_idx]);
        OFS_DATA: begin
          rd_data = xfer_reg[acc_idx];
          rd_ok   = (pwrite == ctrl_reg[acc_idx][CTL_OUT]) ?
                    (pwrite ^ full_reg[acc_idx]) : 1'b1;
        end
        OFS_COND:  rd_data = cond_reg[acc_idx];
        OFS_TIME:  rd_data = {15'h0000, timed_reg[acc_idx], tcnt_reg[acc_idx]};
        OFS_CNT:   rd_data = {16'h0000, cnt_reg[acc_idx]};
        OFS_STAMP: rd_data = {16'h0000, stamp_reg[acc_idx]};
        OFS_STAT:  rd_data = {30'h00000000, timed_reg[acc_idx], full_reg[acc_idx]};
        default:   rd_err  = 1'b1;
      endcase
    end else if (acc_rgn == RGN_CB && acc_idx < 3'(NCB) && paddr[7:5] == 3'h0
                 && paddr[1:0] == 2'h0) begin
      rd_data = {16'h0000, cbcfg_reg[acc_idx]};
    end else if (acc_rgn == RGN_LINK && acc_ofs == 6'h00 && paddr[7:6] == 2'h0) begin
      rd_data = link_reg;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= psel & penable & !pready_reg & (rd_ok | rd_err);
      pslverr_reg <= psel & penable & !pready_reg & rd_err;
      if (psel && penable && !pready_reg && (rd_ok || rd_err)) begin
        prdata_reg <= rd_err ? '0 : rd_data;
      end
    end
  end
endmodule

// file: tip_port_unit_chk.sv
`timescale 1ns/1ps
module tip_port_unit_chk
  import tip_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [AW-1:0]    paddr,
  input wire logic [DW-1:0]    pwdata,
  input wire logic [DW-1:0]    prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [DW-1:0]    pin_i,
  input wire logic [DW-1:0]    pin_o,
  input wire logic [DW-1:0]    pin_oe,
  input wire logic [DW-1:0]    pin_pd,
  input wire logic [NPORT-1:0] strobe_in_i,
  input wire logic [NPORT-1:0] strobe_out_signal,
  input wire logic [NPORT-1:0] port_event
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pd_released: assert property ($past(presetn) |-> pin_pd == '0)
    else $error("pull-downs still on after reset");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  chk_ready_cause: assert property (pready |-> psel && penable && $past(psel))
    else $error("ready without a transfer");
  chk_one_wait: assert property (psel && penable && !$past(penable) |-> !pready)
    else $error("ready in first access cycle");
  chk_err_zero: assert property (pslverr |-> pready && prdata == '0)
    else $error("error answer malformed");
  chk_err_unmapped: assert property (pready && paddr[11:10] != 2'b00 |-> pslverr)
    else $error("unmapped access not refused");
  chk_idle_quiet: assert property (!psel |-> !pready && !pslverr)
    else $error("answer while idle");
  chk_strobe_gap: assert property (strobe_out_signal[4] |=> !strobe_out_signal[4])
    else $error("strobe wider than one cycle");
endmodule
bind tip_port_unit tip_port_unit_chk tip_port_unit_chk_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_i, .pin_o, .pin_oe, .pin_pd,
  .strobe_in_i, .strobe_out_signal, .port_event);

// file: tip_pin_model.sv
`timescale 1ns/1ps
module tip_pin_model
  import tip_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic [DW-1:0] pin_o,
  input  wire logic [DW-1:0] pin_oe,
  input  wire logic [DW-1:0] pin_pd,
  input  wire logic [DW-1:0] ext_val,
  input  wire logic [DW-1:0] ext_drv,
  output logic      [DW-1:0] pin_i
);
  logic alt = 1'b0;
  // A floating pin wobbles so a stale level is never mistaken for data.
  always @(posedge pclk) alt <= ~alt;
  always_comb begin
    for (int b = 0; b < DW; b++) begin
      if (pin_oe[b]) pin_i[b] = pin_o[b];
      else if (ext_drv[b]) pin_i[b] = ext_val[b];
      else if (pin_pd[b]) pin_i[b] = 1'b0;
      else pin_i[b] = alt;
    end
  end
endmodule

// file: timed_io_port_with_clock_blocks_bench.sv
`timescale 1ns/1ps
module timed_io_port_with_clock_blocks_bench
  import tip_pkg::*;
;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [AW-1:0]    paddr;
  logic [DW-1:0]    pwdata, prdata, pin_i, pin_o, pin_oe, pin_pd, ext_val, ext_drv, rd, c0;
  logic [NPORT-1:0] strobe_in_i, strobe_out_signal, port_event;
  int               miscompares, n_tests;
  logic [AW-1:0]    r_a [8] = '{12'h000, 12'h080, 12'h100, 12'h10C, 12'h200, 12'h214,
                                12'h300, 12'h400};
  logic [DW-1:0]    r_e [8] = '{{23'h0, CTRL_RST}, {23'h0, CTRL_RST}, {23'h0, CTRL_RST}, '0,
                                {16'h0, CBCFG_RST}, {16'h0, CBCFG_RST}, '0, '0};
  logic             r_r [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  tip_port_unit tip_port_unit_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin_i, .pin_o, .pin_oe, .pin_pd, .strobe_in_i,
    .strobe_out_signal, .port_event);
  tip_pin_model tip_pin_model_inst (.pclk, .pin_o, .pin_oe, .pin_pd, .ext_val, .ext_drv,
    .pin_i);
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The answer and its data are taken only at the rising edge that sees pready high.
    for (i = 0; i < 400; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i >= 400) begin
      miscompares++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Which: 0 pin value, 1 pin enable, 2 port events, 3 outgoing strobes.
  task automatic waitv(input int which, input logic [DW-1:0] m, input logic [DW-1:0] v);
    int i;
    logic [DW-1:0] cur;
    for (i = 0; i < 400; i++) begin
      @(negedge pclk);
      case (which)
        0: cur = pin_o;
        1: cur = pin_oe;
        2: cur = {27'h0, port_event};
        default: cur = {27'h0, strobe_out_signal};
      endcase
      if ((cur & m) === v) break;
    end
    if (i >= 400) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_val, ext_drv, strobe_in_i} = '0;
    repeat (2) @(posedge pclk);
    check("pd_in_reset", pin_pd, '1);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check("pd_after", pin_pd, '0);
    for (int k = 0; k < 8; k++) begin
      apb(1'b0, r_a[k], '0);
      check("reset_read", rd, r_e[k]);
      check("reset_err", {31'h0, er}, {31'h0, r_r[k]});
    end
    $display("test reset values done");
    // Idle input ports keep sampling, so only port 4 is known in the event check.
    apb(1'b1, 12'h100, 32'h3);
    apb(1'b1, 12'h104, 32'h5A5A00FF);
    waitv(0, '1, 32'h5A5A00FF);
    check("wide_oe", pin_oe, '1);
    check("out_event", {31'h0, port_event[4]}, 32'h1);
    apb(1'b0, 12'h110, '0);
    c0 = rd;
    repeat (100) @(posedge pclk);
    apb(1'b0, 12'h110, '0);
    check("cnt_rate", {16'h0, rd[15:0] - c0[15:0]}, 32'h34);
    $display("test output and counter done");
    apb(1'b1, 12'h300, 32'h2);
    waitv(1, '1, 32'hFFFFFFFD);
    apb(1'b1, 12'h300, '0);
    apb(1'b1, 12'h080, 32'h1);
    waitv(1, '1, 32'hFFFFFF00);
    apb(1'b1, 12'h080, '0);
    apb(1'b1, 12'h100, 32'h7);
    waitv(1, '1, 32'hA5A5FF00);
    $display("test pin sharing and open drain done");
    apb(1'b0, 12'h110, '0);
    c0 = rd;
    apb(1'b1, 12'h10C, {15'h0, 1'b1, c0[15:0] + 16'h003C});
    apb(1'b1, 12'h104, 32'h12345678);
    check("early", pin_oe, 32'hA5A5FF00);
    waitv(3, 32'h10, 32'h10);
    check("strobe_out", {27'h0, strobe_out_signal}, 32'h10);
    waitv(1, '1, ~32'h12345678);
    apb(1'b0, 12'h114, '0);
    check("stamp", rd, {16'h0, c0[15:0] + 16'h003C});
    $display("test timed transfer done");
    apb(1'b1, 12'h100, '0);
    ext_drv <= 32'h0000000F;
    ext_val <= 32'h00000009;
    apb(1'b1, 12'h048, 32'h9);
    apb(1'b1, 12'h040, 32'h141);
    // Port 1 filled its transfer register while idle; drain it before the gated wait.
    apb(1'b0, 12'h044, '0);
    repeat (20) @(posedge pclk);
    apb(1'b0, 12'h058, '0);
    check("gated", rd & 32'h1, '0);
    strobe_in_i <= 5'h02;
    waitv(2, 32'h2, 32'h2);
    apb(1'b0, 12'h044, '0);
    check("in_data", rd, 32'h9);
    strobe_in_i <= '0;
    $display("test conditional input done");
    apb(1'b1, 12'h204, 32'h101);
    apb(1'b1, 12'h0C0, 32'h8);
    apb(1'b0, 12'h0D0, '0);
    c0 = rd;
    repeat (8) begin
      ext_val[0] <= 1'b0;
      repeat (4) @(posedge pclk);
      ext_val[0] <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    apb(1'b0, 12'h0D0, '0);
    check("ext_clock", {16'h0, rd[15:0] - c0[15:0]}, 32'h4);
    $display("test external clock block done");
    report_and_stop();
  end
endmodule
